// ===== adc_result_output_port.sv
// Purpose: Result output port of a sampling converter, parallel or serial.
// Assumes: Mode straps and clock_edge_invert change only between reads.
// Notes: External serial clock logic runs in its own domain, cleared by
// chip select; the result word is replaced at every conversion end, even mid-read.
`timescale 1ns/10ps
`include "adc_result_output_port_cfg.svh"

module adc_result_output_port #(
	parameter int CONV_CYCLES = `CONV_CYCLES,
	parameter int QUARTER_CYCLES = `SCLK_QUARTER_CYCLES,
	parameter int ERR_PULSE_CYCLES = `ERR_PULSE_CYCLES
) (
	input wire logic i_clock, // System clock, 100 MHz.
	input wire logic i_resetn, // Asynchronous reset, active low.
	input wire logic i_sclk_ext, // External serial clock from shared pin.
	input wire logic i_serial_parallel_select, // High selects serial.
	input wire logic i_clock_source_select, // High selects external clock.
	input wire logic i_clock_edge_invert, // Serial clock edge select.
	input wire logic i_frame_sync_invert, // Frame sync polarity.
	input wire logic i_read_mode_or_chain_in, // Daisy chain data input.
	input wire logic i_chip_select_n, // Chip select, active low.
	input wire logic i_read_strobe_n, // Read strobe, active low.
	input wire logic i_reset_pin, // Converter reset pin, active high.
	input wire logic i_conv_start, // Conversion start pulse, same clock.
	input wire logic [15:0] i_conv_data, // Result from the converter core.
	output logic o_pin_d8, // Result bit 8 or serial_data_out.
	output logic o_pin_d8_oe, // Output enable of pin d8.
	output logic o_pin_d9, // Result bit 9 or serial clock out.
	output logic o_pin_d9_oe, // Output enable of pin d9.
	output logic o_pin_d10, // Result bit 10 or frame_sync.
	output logic o_pin_d10_oe, // Output enable of pin d10.
	output logic o_pin_d11, // Result bit 11 or read_error_flag.
	output logic o_pin_d11_oe, // Output enable of pin d11.
	output logic [3:0] o_result_bits_hi, // Result bits 12 to 15.
	output logic o_result_bits_hi_oe, // Output enable of bits 12 to 15.
	output logic o_busy // Conversion in progress.
);

	if (CONV_CYCLES < 2 || CONV_CYCLES > 65536 || QUARTER_CYCLES < 1
			|| QUARTER_CYCLES > 65536 || ERR_PULSE_CYCLES < 1
			|| ERR_PULSE_CYCLES > 255) begin
		$error("adc_result_output_port: counts out of range");
	end

	// =========================================================
	// Pin synchronisers
	// =========================================================
	adc_result_output_port_pkg::pin_sync_t meta_q;
	adc_result_output_port_pkg::pin_sync_t pins_q;
	logic link_reading;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= '{default: 1'b0};
			pins_q <= '{default: 1'b0};
		end else begin
			meta_q <= '{
				reset_pin: i_reset_pin,
				serial_parallel_select: i_serial_parallel_select,
				clock_source_select: i_clock_source_select,
				frame_sync_invert: i_frame_sync_invert,
				chip_select_n: i_chip_select_n,
				read_strobe_n: i_read_strobe_n,
				link_reading: link_reading
			};
			pins_q <= meta_q;
		end
	end

	// =========================================================
	// Edge select synchroniser
	// =========================================================
	// The master clock polarity is system-clock logic, so it reads only the
	// synced copy; the slave output mux still uses the raw pin.
	logic cei_meta_q;
	logic cei_q;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			cei_meta_q <= 1'b0;
			cei_q <= 1'b0;
		end else begin
			cei_meta_q <= i_clock_edge_invert;
			cei_q <= cei_meta_q;
		end
	end

	logic read_en;
	logic serial_mode;
	logic ext_mode;
	logic conv_rst;
	assign read_en = !pins_q.chip_select_n && !pins_q.read_strobe_n;
	assign serial_mode = pins_q.serial_parallel_select;
	assign ext_mode = pins_q.clock_source_select;
	assign conv_rst = pins_q.reset_pin;

	// =========================================================
	// Conversion timing and result latch
	// =========================================================
	logic busy_q;
	logic [15:0] conv_cnt_q;
	logic [15:0] result_q;
	logic conv_done;
	assign conv_done = busy_q && !conv_rst
		&& (conv_cnt_q == 16'(CONV_CYCLES - 1));

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_q <= 1'b0;
			conv_cnt_q <= 16'h0000;
			result_q <= 16'h0000;
		end else if (conv_rst) begin
			busy_q <= 1'b0;
			conv_cnt_q <= 16'h0000;
			result_q <= 16'h0000;
		end else if (busy_q) begin
			if (conv_done) begin
				busy_q <= 1'b0;
				result_q <= i_conv_data;
			end else begin
				conv_cnt_q <= conv_cnt_q + 16'h0001;
			end
		end else if (i_conv_start) begin
			busy_q <= 1'b1;
			conv_cnt_q <= 16'h0000;
		end
	end

	// =========================================================
	// Incomplete read error
	// =========================================================
	// A slave read still running when a conversion lands loses its word;
	// the new result replaces it and the flag pulses.
	logic [7:0] err_cnt_q;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			err_cnt_q <= 8'h00;
		end else if (conv_rst) begin
			err_cnt_q <= 8'h00;
		end else if (conv_done && serial_mode && ext_mode
				&& pins_q.link_reading) begin
			err_cnt_q <= 8'(ERR_PULSE_CYCLES);
		end else if (err_cnt_q != 8'h00) begin
			err_cnt_q <= err_cnt_q - 8'h01;
		end
	end

	// =========================================================
	// Internal serial clock master
	// =========================================================
	// Each bit spans four quarters: data moves at quarter 0 and the clock
	// edges fall at quarters 1 and 3, so data is steady on both edges.
	adc_result_output_port_pkg::master_state_t state_q;
	logic [15:0] quarter_cnt_q;
	logic [1:0] phase_q;
	logic [3:0] bit_q;
	logic [15:0] sr_q;
	logic quarter_end;
	assign quarter_end = quarter_cnt_q == 16'(QUARTER_CYCLES - 1);

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= adc_result_output_port_pkg::ST_IDLE;
			quarter_cnt_q <= 16'h0000;
			phase_q <= 2'h0;
			bit_q <= 4'h0;
			sr_q <= 16'h0000;
		end else if (conv_rst || !read_en || !serial_mode || ext_mode) begin
			state_q <= adc_result_output_port_pkg::ST_IDLE;
			quarter_cnt_q <= 16'h0000;
			phase_q <= 2'h0;
			bit_q <= 4'h0;
		end else begin
			unique case (state_q)
				adc_result_output_port_pkg::ST_IDLE: begin
					if (!busy_q) begin
						state_q <= adc_result_output_port_pkg::ST_SHIFT;
						sr_q <= result_q;
					end
				end
				adc_result_output_port_pkg::ST_SHIFT: begin
					if (quarter_end) begin
						quarter_cnt_q <= 16'h0000;
						phase_q <= phase_q + 2'h1;
						if (phase_q == 2'h3) begin
							sr_q <= {sr_q[14:0], 1'b0};
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'hF) begin
								state_q <= adc_result_output_port_pkg::ST_DONE;
							end
						end
					end else begin
						quarter_cnt_q <= quarter_cnt_q + 16'h0001;
					end
				end
				adc_result_output_port_pkg::ST_DONE: begin
					state_q <= adc_result_output_port_pkg::ST_DONE;
				end
				default: begin
					state_q <= adc_result_output_port_pkg::ST_IDLE;
				end
			endcase
		end
	end

	logic int_sclk;
	logic frame_active;
	assign int_sclk = (phase_q == 2'h1 || phase_q == 2'h2)
		^ cei_q;
	assign frame_active = state_q == adc_result_output_port_pkg::ST_SHIFT;

	// =========================================================
	// External serial clock domain
	// =========================================================
	// Chip select high clears this logic at once, so clock edges outside
	// a selected read do nothing and the frame ends with the select.
	logic link_clear;
	assign link_clear = i_chip_select_n || !i_resetn;

	function automatic logic [16:0] link_shift(input logic [4:0] cnt,
			input logic [16:0] sr, input logic [15:0] word,
			input logic chain);
		logic [16:0] nxt;
		// The first edge loads the word and keeps that edge's chain bit
		// too, so the chain leaves exactly sixteen edges after it came.
		nxt = (cnt == 5'h00) ? {word, chain}
			: {sr[15:0], chain};
		return nxt;
	endfunction

	logic [4:0] rise_cnt_q;
	logic [16:0] rise_sr_q;
	logic [4:0] fall_cnt_q;
	logic [16:0] fall_sr_q;

	always_ff @(posedge i_sclk_ext or posedge link_clear) begin
		if (link_clear) begin
			rise_cnt_q <= 5'h00;
			rise_sr_q <= 17'h00000;
		end else begin
			rise_sr_q <= link_shift(rise_cnt_q, rise_sr_q, result_q,
				i_read_mode_or_chain_in);
			if (rise_cnt_q != 5'(`CHAIN_DELAY)) begin
				rise_cnt_q <= rise_cnt_q + 5'h01;
			end
		end
	end

	always_ff @(negedge i_sclk_ext or posedge link_clear) begin
		if (link_clear) begin
			fall_cnt_q <= 5'h00;
			fall_sr_q <= 17'h00000;
		end else begin
			fall_sr_q <= link_shift(fall_cnt_q, fall_sr_q, result_q,
				i_read_mode_or_chain_in);
			if (fall_cnt_q != 5'(`CHAIN_DELAY)) begin
				fall_cnt_q <= fall_cnt_q + 5'h01;
			end
		end
	end

	logic [4:0] link_cnt;
	logic link_serial_data_out;
	assign link_cnt = i_clock_edge_invert ? fall_cnt_q : rise_cnt_q;
	assign link_serial_data_out = i_clock_edge_invert ? fall_sr_q[16] : rise_sr_q[16];
	assign link_reading = (link_cnt != 5'h00)
		&& (link_cnt < 5'(`CHAIN_DELAY));

	// =========================================================
	// Pin drivers
	// =========================================================
	logic d8_q;
	logic d8_oe_q;
	logic d9_q;
	logic d9_oe_q;
	logic d10_q;
	logic d10_oe_q;
	logic d11_q;
	logic d11_oe_q;
	logic [3:0] hi_q;
	logic hi_oe_q;
	logic ext_serial_q;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			hi_q <= 4'h0;
			hi_oe_q <= 1'b0;
			d8_q <= 1'b0;
			d8_oe_q <= 1'b0;
			ext_serial_q <= 1'b0;
		end else begin
			hi_q <= result_q[`HI_MSB:`HI_LSB];
			hi_oe_q <= read_en;
			d8_q <= serial_mode ? sr_q[15] : result_q[`PIN_D8];
			d8_oe_q <= read_en;
			ext_serial_q <= serial_mode && ext_mode;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			d9_q <= 1'b0;
			d9_oe_q <= 1'b0;
		end else if (!serial_mode) begin
			d9_q <= result_q[`PIN_D9];
			d9_oe_q <= read_en;
		end else begin
			d9_q <= ext_mode ? 1'b0 : int_sclk;
			d9_oe_q <= read_en && !ext_mode;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			d10_q <= 1'b0;
			d10_oe_q <= 1'b0;
		end else if (!serial_mode) begin
			d10_q <= result_q[`PIN_D10];
			d10_oe_q <= read_en;
		end else begin
			d10_q <= frame_active ^ pins_q.frame_sync_invert;
			d10_oe_q <= read_en;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			d11_q <= 1'b0;
			d11_oe_q <= 1'b0;
		end else if (!serial_mode) begin
			d11_q <= result_q[`PIN_D11];
			d11_oe_q <= read_en;
		end else begin
			d11_q <= ext_mode && (err_cnt_q != 8'h00);
			d11_oe_q <= ext_mode;
		end
	end

	// Serial data in slave mode must follow the link clock directly, so it
	// bypasses the system-clock output flop.
	assign o_pin_d8 = ext_serial_q ? link_serial_data_out : d8_q;
	assign o_pin_d8_oe = d8_oe_q;
	assign o_pin_d9 = d9_q;
	assign o_pin_d9_oe = d9_oe_q;
	assign o_pin_d10 = d10_q;
	assign o_pin_d10_oe = d10_oe_q;
	assign o_pin_d11 = d11_q;
	assign o_pin_d11_oe = d11_oe_q;
	assign o_result_bits_hi = hi_q;
	assign o_result_bits_hi_oe = hi_oe_q;
	assign o_busy = busy_q;

endmodule

// ===== adc_result_output_port_cfg.svh
// Purpose: Constants of the converter result output port.
// Assumes: Included by its bare name; definitions only.
// Notes: Times are in ns; cycle counts derive from the system clock rate.
`ifndef ADC_RESULT_OUTPUT_PORT_CFG_SVH
`define ADC_RESULT_OUTPUT_PORT_CFG_SVH

`define CLOCK_MHZ 100
`define RESULT_BITS 16
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS * `CLOCK_MHZ + 999) / 1000)
`define SCLK_QUARTER_NS 20
`define SCLK_QUARTER_CYCLES ((`SCLK_QUARTER_NS * `CLOCK_MHZ + 999) / 1000)
`define ERR_PULSE_NS 40
`define ERR_PULSE_CYCLES ((`ERR_PULSE_NS * `CLOCK_MHZ + 999) / 1000)
`define PIN_D8 8
`define PIN_D9 9
`define PIN_D10 10
`define PIN_D11 11
`define HI_LSB 12
`define HI_MSB 15
`define CHAIN_DELAY 16

`endif

// ===== adc_result_output_port_pkg.sv
// Purpose: Types shared by the converter result output port.
// Assumes: Used by scope only, never imported.
// Notes: Mode straps travel as one packed struct.
package adc_result_output_port_pkg;

	typedef struct packed {
		logic reset_pin;
		logic serial_parallel_select;
		logic clock_source_select;
		logic frame_sync_invert;
		logic chip_select_n;
		logic read_strobe_n;
		logic link_reading;
	} pin_sync_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE = 2'b11
	} master_state_t;

endpackage

// ===== adc_result_output_port_chk.sv
// Purpose: Port-level assertions for the converter result output port.
// Assumes: Mode inputs change only while no read is in progress.
// Notes: The reset pin also disables the checks while it is high, except a_busy_abort.
`timescale 1ns/10ps
module adc_result_output_port_chk #(
	parameter int CONV_CYCLES = 100
) (
	input wire logic i_clock, // Clock.
	input wire logic i_resetn, // Reset.
	input wire logic i_serial_parallel_select, // Serial when high.
	input wire logic i_clock_source_select, // External when high.
	input wire logic i_frame_sync_invert, // Sync polarity.
	input wire logic i_chip_select_n, // Select.
	input wire logic i_read_strobe_n, // Read.
	input wire logic i_reset_pin, // Reset pin.
	input wire logic i_conv_start, // Start.
	input wire logic o_pin_d8_oe, // Pin 8 enable.
	input wire logic o_pin_d9_oe, // Pin 9 enable.
	input wire logic o_pin_d10, // Pin 10.
	input wire logic o_pin_d11, // Pin 11.
	input wire logic o_result_bits_hi_oe, // High bits enable.
	input wire logic o_busy // Busy.
);
	// ==========================================================
	// Assertions
	localparam int HOLD = CONV_CYCLES - 1;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn || i_reset_pin);
	sequence s_read5;
		(!i_chip_select_n && !i_read_strobe_n) [*5];
	endsequence
	sequence s_idle5;
		(i_chip_select_n || i_read_strobe_n) [*5];
	endsequence
	a_busy_start: assert property (
		i_conv_start && !o_busy |=> o_busy)
		else $error("busy did not follow start");
	a_busy_length: assert property (
		$rose(o_busy) |-> ##HOLD o_busy ##1 !o_busy)
		else $error("busy length wrong");
	a_busy_abort: assert property (disable iff (!i_resetn)
		i_reset_pin [*5] |-> !o_busy)
		else $error("conversion not aborted");
	a_bus_enable: assert property (
		s_read5 |-> o_result_bits_hi_oe)
		else $error("output bus not enabled");
	a_bus_float: assert property (
		s_idle5 |-> !o_result_bits_hi_oe && !o_pin_d8_oe)
		else $error("output bus still driven");
	a_ext_clock: assert property (
		(i_serial_parallel_select && i_clock_source_select) [*5]
		|-> !o_pin_d9_oe)
		else $error("device drives external clock");
	a_frame_len: assert property (
		i_serial_parallel_select && !i_clock_source_select &&
		$changed(o_pin_d10) && o_pin_d10 != i_frame_sync_invert
		|-> ##126 (o_pin_d10 != i_frame_sync_invert)
		##[1:4] (o_pin_d10 == i_frame_sync_invert))
		else $error("frame sync length wrong");
	a_err_pulse: assert property (
		$rose(o_pin_d11) && i_serial_parallel_select &&
		i_clock_source_select |-> o_pin_d11 [*4] ##[1:2] !o_pin_d11)
		else $error("error pulse length wrong");
	a_err_cause: assert property (
		$rose(o_pin_d11) && i_serial_parallel_select &&
		i_clock_source_select
		|-> $past(o_busy) || $past(o_busy, 2) || $past(o_busy, 3))
		else $error("error flag without conversion end");
endmodule

bind adc_result_output_port adc_result_output_port_chk #(
	.CONV_CYCLES(CONV_CYCLES)
) u_chk (
	.i_clock(i_clock),
	.i_resetn(i_resetn),
	.i_serial_parallel_select(i_serial_parallel_select),
	.i_clock_source_select(i_clock_source_select),
	.i_frame_sync_invert(i_frame_sync_invert),
	.i_chip_select_n(i_chip_select_n),
	.i_read_strobe_n(i_read_strobe_n),
	.i_reset_pin(i_reset_pin),
	.i_conv_start(i_conv_start),
	.o_pin_d8_oe(o_pin_d8_oe),
	.o_pin_d9_oe(o_pin_d9_oe),
	.o_pin_d10(o_pin_d10),
	.o_pin_d11(o_pin_d11),
	.o_result_bits_hi_oe(o_result_bits_hi_oe),
	.o_busy(o_busy)
);

// ===== serial_host.sv
// Purpose: Serial host that clocks results out of the converter port.
// Assumes: Called only while no other frame runs.
// Notes: The clock stands at its idle level outside frames.
`timescale 1ns/10ps
module serial_host (
	input wire logic i_edge_invert, // Idle clock level.
	input wire logic i_sdo, // Serial data pin.
	input wire logic [15:0] i_chain_word, // Word for the chain input.
	output logic o_sclk, // Serial clock.
	output logic o_chain, // Chain data.
	output logic [31:0] o_word // Bits taken, newest lowest.
);
	initial begin
		o_sclk = 1'b0;
		o_chain = 1'b0;
		o_word = 32'h0;
	end
	always @(i_edge_invert) o_sclk = i_edge_invert;
	// ==========================================================
	// Frame
	task automatic frame(input int n);
		o_chain = i_chain_word[15];
		#3;
		for (int k = 1; k <= n; k++) begin
			#6 o_sclk = ~i_edge_invert;
			#6 o_sclk = i_edge_invert;
			o_word = {o_word[30:0], i_sdo};
			// Past the word the chain line toggles, never holds.
			o_chain = (k < 16) ? i_chain_word[15 - k] : ~o_chain;
		end
	endtask
endmodule

// ===== tb.sv
// Purpose: Self-checking bench of the converter result output port.
// Assumes: The serial host model supplies the external clock.
// Notes: Conversion is shortened to eight cycles.
`timescale 1ns/10ps
module tb;
	localparam int CONV = 8;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic sps = 1'b0;
	logic css = 1'b0;
	logic cei = 1'b0;
	logic fsi = 1'b0;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic rst_pin = 1'b0;
	logic start = 1'b0;
	logic [15:0] cdata = 16'h0000;
	logic [15:0] chain_w = 16'h6B2D;
	logic [15:0] dv;
	logic [15:0] got;
	logic d8, d8_oe, d9, d9_oe, d10, d10_oe, d11, d11_oe, hi_oe, busy;
	logic [3:0] hi;
	logic sclk_h, chain, seen;
	logic [31:0] word;
	wire sclk_pin = d9_oe ? d9 : sclk_h;
	wire sdo_pin = d8_oe ? d8 : 1'bz;
	int err_count = 0;
	int comparisons = 0;
	always #5 i_clock = ~i_clock;
	adc_result_output_port #(
		.CONV_CYCLES(CONV)
	) u_adc_result_output_port (
		.i_clock(i_clock), .i_resetn(i_resetn), .i_sclk_ext(sclk_pin),
		.i_serial_parallel_select(sps), .i_clock_source_select(css),
		.i_clock_edge_invert(cei), .i_frame_sync_invert(fsi),
		.i_read_mode_or_chain_in(chain), .i_chip_select_n(cs_n),
		.i_read_strobe_n(rd_n), .i_reset_pin(rst_pin),
		.i_conv_start(start), .i_conv_data(cdata),
		.o_pin_d8(d8), .o_pin_d8_oe(d8_oe), .o_pin_d9(d9),
		.o_pin_d9_oe(d9_oe), .o_pin_d10(d10), .o_pin_d10_oe(d10_oe),
		.o_pin_d11(d11), .o_pin_d11_oe(d11_oe), .o_result_bits_hi(hi),
		.o_result_bits_hi_oe(hi_oe), .o_busy(busy)
	);
	serial_host u_serial_host (
		.i_edge_invert(cei), .i_sdo(sdo_pin), .i_chain_word(chain_w),
		.o_sclk(sclk_h), .o_chain(chain), .o_word(word)
	);
	// ==========================================================
	// Tasks
	task check(input string name, input logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask
	task close_out;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task convert(input logic [15:0] d);
		int n;
		@(posedge i_clock);
		cdata <= d;
		start <= 1'b1;
		@(posedge i_clock);
		start <= 1'b0;
		#1;
		check("busy raised", 1, busy);
		for (n = 0; n < 20 && busy !== 1'b0; n++)
			cyc(1);
		check("busy cycles", CONV, n);
	endtask
	task read_on;
		@(posedge i_clock);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
	endtask
	task read_off;
		@(posedge i_clock);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		cyc(5);
	endtask
	// ==========================================================
	// Tests
	initial begin
		cyc(8);
		@(posedge i_clock);
		i_resetn <= 1'b1;
		cyc(3);
		convert(16'hA5C3);
		read_on;
		cyc(5);
		check("par bits", 16'hA5C3 >> 8,
			{hi, d11, d10, d9, d8});
		check("par oe", 5'h1F,
			{hi_oe, d8_oe, d9_oe, d10_oe, d11_oe});
		read_off;
		check("idle oe", 0,
			{hi_oe, d8_oe, d9_oe, d10_oe, d11_oe});
		@(posedge i_clock);
		start <= 1'b1;
		@(posedge i_clock);
		start <= 1'b0;
		rst_pin <= 1'b1;
		cyc(5);
		check("busy after abort", 0, busy);
		@(posedge i_clock);
		rst_pin <= 1'b0;
		cyc(5);
		for (int i = 0; i < 2; i++) begin
			@(posedge i_clock);
			sps <= 1'b1;
			fsi <= i[0];
			cei <= i[0];
			dv = i ? 16'h4E71 : 16'h9C35;
			convert(dv);
			read_on;
			for (int k = 0; k < 10 && d10 !== ~fsi; k++)
				cyc(1);
			check("hi bits", dv[15:12], hi);
			cyc(4);
			for (int b = 15; b >= 0; b--) begin
				got[b] = d8;
				cyc(8);
			end
			check("master word", dv, got);
			check("sync idle", fsi, d10);
			check("clock driven", 1, d9_oe);
			check("clock idle", cei, d9);
			read_off;
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge i_clock);
			css <= 1'b1;
			fsi <= 1'b0;
			cei <= i[0];
			dv = i ? 16'h3C5A : 16'hE817;
			convert(dv);
			u_serial_host.frame(4);
			read_on;
			cyc(5);
			u_serial_host.frame(32);
			check("slave word", {dv, chain_w},
				word);
			read_off;
		end
		@(posedge i_clock);
		cei <= 1'b0;
		convert(16'h0F0F);
		read_on;
		cyc(5);
		u_serial_host.frame(8);
		seen = 1'b0;
		convert(16'hF00F);
		for (int k = 0; k < 10; k++) begin
			seen = seen | (d11 === 1'b1);
			cyc(1);
		end
		check("error pulse", 1, seen);
		check("flag driven", 1, d11_oe);
		read_off;
		read_on;
		cyc(5);
		u_serial_host.frame(16);
		check("new result", 16'hF00F, word[15:0]);
		read_off;
		close_out;
	end
	initial begin
		#100000;
		err_count++;
		close_out;
	end
endmodule
